// >>> logic/wd_reset_cause_map.svh
/*
  Register offsets, field positions, reset values and counts of the
  watchdog and reset-cause block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef WD_RESET_CAUSE_MAP_SVH
`define WD_RESET_CAUSE_MAP_SVH

// apb byte addresses, one aligned word each
`define WD_RESET_CAUSE_ADDR_CAUSE        12'h000
`define WD_RESET_CAUSE_ADDR_CONTROL      12'h004

// reset_cause_flags fields
`define WD_RESET_CAUSE_CAUSE_POWERON     0
`define WD_RESET_CAUSE_CAUSE_PIN         1
`define WD_RESET_CAUSE_CAUSE_BROWNOUT    2
`define WD_RESET_CAUSE_CAUSE_WD          3
`define WD_RESET_CAUSE_CAUSE_RESET       4'h1

// watchdog_control fields
`define WD_RESET_CAUSE_CTL_PRESCALE_LO   0
`define WD_RESET_CAUSE_CTL_RESET_EN      3
`define WD_RESET_CAUSE_CTL_UNLOCK        4
`define WD_RESET_CAUSE_CTL_PRESCALE_MSB  5
`define WD_RESET_CAUSE_CTL_IRQ_EN        6
`define WD_RESET_CAUSE_CTL_IRQ_FLAG      7
`define WD_RESET_CAUSE_PRESCALE_RESET    4'h0

// timing counts
`define WD_RESET_CAUSE_UNLOCK_CYCLES     3'h4
`define WD_RESET_CAUSE_TIMEOUT_BASE      2048
`define WD_RESET_CAUSE_PRESCALE_MAX      4'h9
`define WD_RESET_CAUSE_SLOW_OSC_HZ       128000

`endif

// >>> logic/wd_reset_cause_pkg.sv
/*
  Types shared by the watchdog and reset-cause block.
  Assumes nothing of its surroundings.
*/
package wd_reset_cause_pkg;
  // watchdog operating mode, codes are {reset enable, interrupt enable}
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ  = 2'b01,
    MODE_RST  = 2'b10,
    MODE_BOTH = 2'b11
  } wd_reset_cause_mode_t;
endpackage

// >>> logic/wd_reset_cause_sync2.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level; no bit relation survives the crossing.
*/
`timescale 1ns/1ps
`default_nettype none

module wd_reset_cause_sync2 #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage is read only by the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule

`default_nettype wire

// >>> logic/wd_reset_cause_top.sv
/*
  Watchdog timer with reset-cause flags behind an APB slave.
  Assumes arst_n is the power-on reset; other reset sources, slow oscillator
  and fuse arrive asynchronously; cpu strobes are synchronous to clock.
*/
// How it works
// - watchdog reset sets cause bit 3; power-on or written zero clears it
// - brown-out sets cause bit 2; power-on or written zero clears it
// - pin reset sets cause bit 1; power-on or written zero clears it
// - power-on sets cause bit 0; only a written zero clears it
// - time-out in interrupt operation sets control bit 7; vector or written one clears
// - interrupt requested when global enable, bit 6 and flag are all set
// - reset-enable and interrupt-enable bits select stopped, interrupt, reset or both
// - combined mode first time-out sets flag; vector clears flag and enable
// - combined mode second time-out with flag still pending forces system reset
// - programmed always-on fuse forces system reset mode
// - clearing reset enable or changing prescale needs change enable set first
// - change enable clears itself four clock cycles after being written
// - reset enable held set while watchdog cause flag is set
// - prescale field is bits 5 and 2:0, bit 5 most significant
// - codes 0 to 9 select 2048 to 1048576 slow cycles, doubling
// - upper 28 cause bits are read-only zero
// - counter advances on slow oscillator cycles, seen through the synchroniser on system clock
// - time-out in reset mode gives a one-cycle system reset pulse
// - restart strobe clears the counter; software restarts before time-out
`timescale 1ns/1ps
`default_nettype none
`include "wd_reset_cause_map.svh"

module wd_reset_cause_top #(
  parameter int unsigned TIMEOUT_BASE = `WD_RESET_CAUSE_TIMEOUT_BASE,
  parameter int unsigned CNT_W        = 21
) (
  // clock and power-on reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // asynchronous sources
  input  wire logic        slow_osc,
  input  wire logic        always_on_fuse,
  input  wire logic        brownout_reset,
  input  wire logic        pin_reset,
  // cpu side
  input  wire logic        wd_restart,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  // results
  output logic             timeout_irq,
  output logic             sys_reset
);
  logic [3:0]             sync_q;
  logic                   osc_s;
  logic                   fuse_s;
  logic                   bo_s;
  logic                   pin_s;
  logic                   osc_prev_reg;
  logic                   slow_tick;
  logic                   fuse_prog_reg;
  logic                   pready_reg;
  logic [31:0]            prdata_reg;
  logic                   pslverr_reg;
  logic                   setup;
  logic                   hit_cause;
  logic                   hit_ctl;
  logic                   wr_cause;
  logic                   wr_ctl;
  logic [3:0]             cause_reg;
  logic [3:0]             cause_next;
  logic                   irq_flag_reg;
  logic                   irq_en_reg;
  logic                   reset_en_reg;
  logic                   reset_en_next;
  logic                   unlock_reg;
  logic [2:0]             unlock_cnt_reg;
  logic [3:0]             prescale_reg;
  logic [3:0]             prescale_next;
  logic                   irq_en_eff;
  logic                   reset_en_eff;
  logic [7:0]             ctl_rd;
  logic                   ctl_init;
  logic                   timeout;
  logic                   act_irq;
  logic                   act_rst;
  logic                   sys_reset_reg;
  logic                   timeout_irq_reg;
  wd_reset_cause_pkg::wd_reset_cause_mode_t   mode;

  // asynchronous levels; fuse resets to unprogrammed
  wd_reset_cause_sync2 #(
    .WIDTH   (4),
    .RST_VAL (4'h4)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({slow_osc, always_on_fuse, brownout_reset, pin_reset}),
    .q      (sync_q)
  );
  assign osc_s  = sync_q[3];
  assign fuse_s = sync_q[2];
  assign bo_s   = sync_q[1];
  assign pin_s  = sync_q[0];

  // slow oscillator edge and fuse level, both taken after the synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_prev_reg  <= 1'b0;
      fuse_prog_reg <= 1'b0;
    end else begin
      osc_prev_reg  <= osc_s;
      fuse_prog_reg <= ~fuse_s;
    end
  end
  assign slow_tick = osc_s & ~osc_prev_reg;

  // apb decode; access always completes in its first access cycle
  assign setup     = psel & ~penable;
  assign hit_cause = (paddr == `WD_RESET_CAUSE_ADDR_CAUSE);
  assign hit_ctl   = (paddr == `WD_RESET_CAUSE_ADDR_CONTROL);
  assign wr_cause  = psel & penable & pready_reg & pwrite & hit_cause;
  assign wr_ctl    = psel & penable & pready_reg & pwrite & hit_ctl;

  // effective enables as software sees them
  assign irq_en_eff   = irq_en_reg & ~fuse_prog_reg;
  assign reset_en_eff = reset_en_reg | fuse_prog_reg;
  assign ctl_rd = {irq_flag_reg, irq_en_eff, prescale_reg[3], unlock_reg,
                   reset_en_eff, prescale_reg[2:0]};

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~(hit_cause | hit_ctl);
      if (setup && hit_cause) begin
        prdata_reg <= {28'h000_0000, cause_reg};
      end else if (setup && hit_ctl) begin
        prdata_reg <= {24'h00_0000, ctl_rd};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // mode selection; the fuse overrides both enables
  assign mode = fuse_prog_reg ? wd_reset_cause_pkg::MODE_RST
                              : wd_reset_cause_pkg::wd_reset_cause_mode_t'({reset_en_reg, irq_en_reg});

  // time-out action by mode
  always_comb begin
    act_irq = 1'b0;
    act_rst = 1'b0;
    if (timeout) begin
      case (mode)
        wd_reset_cause_pkg::MODE_STOP: begin
          act_irq = 1'b0;
        end
        wd_reset_cause_pkg::MODE_IRQ: begin
          act_irq = 1'b1;
        end
        wd_reset_cause_pkg::MODE_RST: begin
          act_rst = 1'b1;
        end
        wd_reset_cause_pkg::MODE_BOTH: begin
          // a flag still pending means the handler never ran
          act_rst = irq_flag_reg;
          act_irq = ~irq_flag_reg;
        end
        default: begin
          act_rst = 1'b1;
        end
      endcase
    end
  end

  // any system reset, own or foreign, puts control back to its reset values, except a reset enable held by the watchdog cause
  assign ctl_init = sys_reset_reg | bo_s | pin_s;

  // cause flags; a new cause wins over a software clear in the same cycle
  always_comb begin
    cause_next = cause_reg;
    if (wr_cause) begin
      cause_next = cause_reg & pwdata[3:0];
    end
    cause_next[`WD_RESET_CAUSE_CAUSE_WD]       = cause_next[`WD_RESET_CAUSE_CAUSE_WD] | act_rst;
    cause_next[`WD_RESET_CAUSE_CAUSE_BROWNOUT] = cause_next[`WD_RESET_CAUSE_CAUSE_BROWNOUT] | bo_s;
    cause_next[`WD_RESET_CAUSE_CAUSE_PIN]      = cause_next[`WD_RESET_CAUSE_CAUSE_PIN] | pin_s;
  end

  // power-on sets only its own flag and clears the rest; other resets only add their own flags here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= `WD_RESET_CAUSE_CAUSE_RESET;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // change-enable window, closed by a plain write or after its count
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end else if (ctl_init) begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end else if (wr_ctl && pwdata[`WD_RESET_CAUSE_CTL_UNLOCK]) begin
      unlock_reg     <= 1'b1;
      unlock_cnt_reg <= `WD_RESET_CAUSE_UNLOCK_CYCLES;
    end else if (wr_ctl) begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end else if (unlock_reg) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
      unlock_reg     <= (unlock_cnt_reg != 3'h1);
    end
  end

  // protected fields; setting reset enable is always allowed
  always_comb begin
    reset_en_next = reset_en_reg;
    prescale_next = prescale_reg;
    if (ctl_init) begin
      reset_en_next = 1'b0;
      prescale_next = `WD_RESET_CAUSE_PRESCALE_RESET;
    end else if (wr_ctl) begin
      if (pwdata[`WD_RESET_CAUSE_CTL_RESET_EN]) begin
        reset_en_next = 1'b1;
      end else if (unlock_reg) begin
        reset_en_next = 1'b0;
      end
      if (unlock_reg) begin
        prescale_next = {pwdata[`WD_RESET_CAUSE_CTL_PRESCALE_MSB], pwdata[2:0]};
      end
    end
    // a pending watchdog cause keeps the reset enabled
    if (cause_next[`WD_RESET_CAUSE_CAUSE_WD]) begin
      reset_en_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_en_reg <= 1'b0;
      prescale_reg <= `WD_RESET_CAUSE_PRESCALE_RESET;
    end else begin
      reset_en_reg <= reset_en_next;
      prescale_reg <= prescale_next;
    end
  end

  // interrupt enable; vector clears it only in combined operation
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_reg <= 1'b0;
    end else if (ctl_init) begin
      irq_en_reg <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_reg <= pwdata[`WD_RESET_CAUSE_CTL_IRQ_EN];
    end else if (irq_vector_ack && reset_en_reg) begin
      irq_en_reg <= 1'b0;
    end
  end

  // time-out flag; a fresh time-out wins over any clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_flag_reg <= 1'b0;
    end else if (act_irq) begin
      irq_flag_reg <= 1'b1;
    end else if (ctl_init || irq_vector_ack || (wr_ctl && pwdata[`WD_RESET_CAUSE_CTL_IRQ_FLAG])) begin
      irq_flag_reg <= 1'b0;
    end
  end

  // registered outputs; the request lags its causes by one cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset_reg   <= 1'b0;
      timeout_irq_reg <= 1'b0;
    end else begin
      sys_reset_reg   <= act_rst;
      timeout_irq_reg <= global_irq_enable & irq_en_eff & irq_flag_reg;
    end
  end

  wd_reset_cause_wd_counter #(
    .TIMEOUT_BASE (TIMEOUT_BASE),
    .CNT_W        (CNT_W)
  ) u_counter (
    .clock    (clock),
    .arst_n   (arst_n),
    .tick     (slow_tick),
    .run      (mode != wd_reset_cause_pkg::MODE_STOP),
    .clear    (wd_restart | act_rst | ctl_init | (prescale_next != prescale_reg)),
    .prescale (prescale_reg),
    .timeout  (timeout),
    .count    ()
  );

  assign pready      = pready_reg;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;
  assign sys_reset   = sys_reset_reg;
  assign timeout_irq = timeout_irq_reg;

  AST_WD_CAUSE_SET:
  assert property (@(posedge clock) disable iff (!arst_n) act_rst |=> cause_reg[`WD_RESET_CAUSE_CAUSE_WD])
    else $error("watchdog cause not set after watchdog reset");

  AST_BO_CAUSE_SET:
  assert property (@(posedge clock) disable iff (!arst_n) bo_s |=> cause_reg[`WD_RESET_CAUSE_CAUSE_BROWNOUT] && !irq_en_reg)
    else $error("brown-out cause or control reset missing");

  AST_IRQ_FLAG_SET:
  assert property (@(posedge clock) disable iff (!arst_n)
    (timeout && mode == wd_reset_cause_pkg::MODE_IRQ) |=> irq_flag_reg && !sys_reset)
    else $error("interrupt-mode time-out did not set only the flag");

  AST_IRQ_REQUEST:
  assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |=> timeout_irq == $past(global_irq_enable && irq_en_eff && irq_flag_reg))
    else $error("interrupt request does not follow enables and flag");

  AST_BOTH_SECOND_TIMEOUT:
  assert property (@(posedge clock) disable iff (!arst_n)
    (timeout && mode == wd_reset_cause_pkg::MODE_BOTH && irq_flag_reg) |=> sys_reset ##1 !irq_en_reg)
    else $error("pending second time-out did not reset");

  AST_FUSE_FORCES_RESET:
  assert property (@(posedge clock) disable iff (!arst_n)
    fuse_prog_reg |-> mode == wd_reset_cause_pkg::MODE_RST && reset_en_eff && !irq_en_eff)
    else $error("programmed fuse not in reset mode");

  AST_PRESCALE_LOCKED:
  assert property (@(posedge clock) disable iff (!arst_n)
    (wr_ctl && !unlock_reg && !ctl_init) |=> prescale_reg == $past(prescale_reg))
    else $error("prescale changed without unlock");

  AST_UNLOCK_EXPIRES:
  assert property (@(posedge clock) disable iff (!arst_n)
    (wr_ctl && pwdata[`WD_RESET_CAUSE_CTL_UNLOCK] && !ctl_init) ##1 (!wr_ctl && !ctl_init) [*4] |=> !unlock_reg)
    else $error("change enable outlived four cycles");

  AST_CAUSE_HOLDS_ENABLE:
  assert property (@(posedge clock) disable iff (!arst_n) cause_reg[`WD_RESET_CAUSE_CAUSE_WD] |-> reset_en_reg)
    else $error("reset enable clear while watchdog cause set");

  AST_CAUSE_UPPER_ZERO:
  assert property (@(posedge clock) disable iff (!arst_n)
    (pready_reg && hit_cause) |-> prdata_reg[31:4] == 28'h000_0000)
    else $error("cause register upper bits not zero");

  AST_RESET_ONE_CYCLE:
  assert property (@(posedge clock) disable iff (!arst_n) sys_reset |=> !sys_reset)
    else $error("system reset pulse longer than one cycle");
endmodule

`default_nettype wire

// >>> logic/wd_reset_cause_wd_counter.sv
/*
  Watchdog counter: counts slow-oscillator ticks up to the selected limit.
  Assumes tick is a one-cycle pulse per slow-oscillator period on clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wd_reset_cause_map.svh"

module wd_reset_cause_wd_counter #(
  parameter int unsigned TIMEOUT_BASE = `WD_RESET_CAUSE_TIMEOUT_BASE,
  parameter int unsigned CNT_W        = 21
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // control
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic [3:0]       prescale,
  // result
  output logic                  timeout,
  output logic      [CNT_W-1:0] count
);
  logic [CNT_W-1:0] count_reg;
  logic [3:0]       code_eff;
  logic [CNT_W-1:0] limit;

  // reserved codes fall back to the longest period
  assign code_eff = (prescale > `WD_RESET_CAUSE_PRESCALE_MAX) ? `WD_RESET_CAUSE_PRESCALE_MAX : prescale;
  assign limit    = CNT_W'(TIMEOUT_BASE) << code_eff;
  assign timeout  = run & tick & (count_reg == limit - CNT_W'(1));
  assign count    = count_reg;

  // counting stops and restarts from zero on clear, stop or time-out
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (!run || clear || timeout) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  AST_CNT_ZERO_AFTER_EVENT:
  assert property (@(posedge clock) disable iff (!arst_n) (timeout || clear) |=> count_reg == '0)
    else $error("counter not back at zero after restart or time-out");
endmodule

`default_nettype wire

// >>> verif/tb.sv
/*
  Self-checking bench for the watchdog and reset-cause block, APB master tasks.
  Assumes wd_reset_cause_top answers in the first access cycle and a short TIMEOUT_BASE.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wd_reset_cause_map.svh"

module tb;
  localparam int BASE  = 4;
  localparam int HALF  = 4;
  localparam int LIMIT = 40000;
  // clock, reset and apb
  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  // sources, cpu side and results
  logic        slow_osc;
  logic        always_on_fuse;
  logic        brownout_reset;
  logic        pin_reset;
  logic        wd_restart;
  logic        global_irq_enable;
  logic        irq_vector_ack;
  logic        timeout_irq;
  logic        sys_reset;
  // bookkeeping
  int          n_mismatch;
  int          samples_checked;
  int          cycles;
  int          n_sysrst;
  int          osc_cnt;
  int          c;
  int          n0;
  logic [31:0] r;

  wd_reset_cause_top #(.TIMEOUT_BASE(BASE), .CNT_W(21)) DUT (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .slow_osc(slow_osc), .always_on_fuse(always_on_fuse), .brownout_reset(brownout_reset),
    .pin_reset(pin_reset), .wd_restart(wd_restart), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .timeout_irq(timeout_irq), .sys_reset(sys_reset)
  );

  always #25 clock = ~clock;

  // slow oscillator, reset-pulse counter and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == HALF - 1) begin
      slow_osc <= ~slow_osc;
    end
    if (sys_reset === 1'b1) begin
      n_sysrst <= n_sysrst + 1;
    end
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_range(input string what, input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr_n, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd_d, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_val("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp, input logic exp_err = 1'b0);
    logic [31:0] x;
    logic        e;
    apb(1'b0, a, 32'h0, x, e);
    chk_val(what, exp, x);
    chk_val({what, " slverr"}, {31'h0, exp_err}, {31'h0, e});
  endtask

  // timed unlock followed at once by the new setting
  task automatic set_ctl(input logic [31:0] d);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h18);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, d);
  endtask

  task automatic poll_flag(output logic [31:0] x);
    logic e;
    int   n;
    n = 0;
    do begin
      apb(1'b0, `WD_RESET_CAUSE_ADDR_CONTROL, 32'h0, x, e);
      n++;
    end while (x[7] !== 1'b1 && n < 40);
  endtask

  task automatic strobe(input logic ack);
    @(posedge clock);
    if (ack) irq_vector_ack <= 1'b1;
    else wd_restart <= 1'b1;
    @(posedge clock);
    irq_vector_ack <= 1'b0;
    wd_restart <= 1'b0;
  endtask

  // restart, then count cycles to the reset pulse and check its width
  task automatic measure(input int code);
    int exp;
    exp = (BASE << code) * 2 * HALF;
    c = 0;
    strobe(1'b0);
    while (sys_reset !== 1'b1 && c < 20000) begin
      @(posedge clock);
      c++;
    end
    chk_range("timeout period", c, exp - 8, exp + 16);
    @(posedge clock);
    chk_val("reset pulse width", 32'h0, {31'h0, sys_reset});
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow_osc = 1'b0;
    always_on_fuse = 1'b1;
    brownout_reset = 1'b0;
    pin_reset = 1'b0;
    wd_restart = 1'b0;
    global_irq_enable = 1'b0;
    irq_vector_ack = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    n_sysrst = 0;
    osc_cnt = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    // cause flags
    rd("cause at reset", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h1);
    rd("control at reset", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h0);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    rd("poweron cleared", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    pin_reset <= 1'b1;
    repeat (4) @(posedge clock);
    pin_reset <= 1'b0;
    rd("pin cause", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h2);
    brownout_reset <= 1'b1;
    repeat (4) @(posedge clock);
    brownout_reset <= 1'b0;
    rd("brownout cause", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h6);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'hFFFFFFFF);
    rd("upper cause bits", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h6);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    rd("causes cleared", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    rd("unmapped", 12'h008, 32'h0, 1'b1);
    $display("test cause flags done");
    // protected fields
    set_ctl(32'h0F);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h18);
    rd("unlock open", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h1F);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h08);
    rd("prescale locked", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h0F);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h07);
    rd("reset enable locked", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h0F);
    set_ctl(32'h20);
    rd("prescale msb", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h20);
    $display("test unlock done");
    // reset mode periods
    set_ctl(32'h08);
    measure(0);
    rd("wd cause", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h8);
    set_ctl(32'h00);
    rd("reset enable held", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h08);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    set_ctl(32'h09);
    measure(1);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    set_ctl(32'h2A);
    measure(9);
    n0 = n_sysrst;
    repeat (12) begin
      repeat (16) @(posedge clock);
      strobe(1'b0);
    end
    chk_range("restart holds off", n_sysrst, n0, n0);
    wr(`WD_RESET_CAUSE_ADDR_CAUSE, 32'h0);
    set_ctl(32'h00);
    rd("stopped", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h00);
    n0 = n_sysrst;
    repeat (300) @(posedge clock);
    chk_range("stopped no reset", n_sysrst, n0, n0);
    $display("test reset mode done");
    // interrupt mode
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h40);
    poll_flag(r);
    chk_val("irq flag", 32'hC0, r);
    chk_val("irq masked", 32'h0, {31'h0, timeout_irq});
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge clock);
    chk_val("irq raised", 32'h1, {31'h0, timeout_irq});
    strobe(1'b1);
    rd("vector clears flag", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h40);
    chk_val("irq dropped", 32'h0, {31'h0, timeout_irq});
    global_irq_enable <= 1'b0;
    poll_flag(r);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'hC0);
    rd("write one clears", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h40);
    $display("test interrupt mode done");
    // combined mode
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h48);
    n0 = n_sysrst;
    poll_flag(r);
    chk_val("combined first", 32'hC8, r);
    chk_range("no reset on first", n_sysrst, n0, n0);
    strobe(1'b1);
    rd("vector to reset mode", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h08);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h48);
    poll_flag(r);
    repeat (40) @(posedge clock);
    chk_range("pending gives reset", n_sysrst, n0 + 1, n0 + 1);
    $display("test combined mode done");
    // second power-on reset, then the fuse
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rd("cause after poweron", `WD_RESET_CAUSE_ADDR_CAUSE, 32'h1);
    wr(`WD_RESET_CAUSE_ADDR_CONTROL, 32'h40);
    always_on_fuse <= 1'b0;
    repeat (5) @(posedge clock);
    rd("fuse forces reset", `WD_RESET_CAUSE_ADDR_CONTROL, 32'h08);
    n0 = n_sysrst;
    repeat (50) @(posedge clock);
    chk_range("fuse reset", n_sysrst, n0 + 1, n0 + 2);
    always_on_fuse <= 1'b1;
    $display("test fuse done");
    results();
  end
endmodule

`default_nettype wire
